// *** src/tlvi_defs.vh ***
// constants of the two-level vectored interrupt handler
`ifndef TLVI_DEFS_VH
`define TLVI_DEFS_VH
`define TLVI_NSRC 17
`define TLVI_ADR_PRI_EN 6'h00
`define TLVI_ADR_PRI_PR 6'h04
`define TLVI_ADR_EXT_EN_A 6'h08
`define TLVI_ADR_EXT_PR_A 6'h0C
`define TLVI_ADR_EXT_EN_B 6'h10
`define TLVI_ADR_EXT_PR_B 6'h14
`define TLVI_ADR_PEND 6'h18
`define TLVI_ADR_STAT 6'h1C
`define TLVI_GLOBAL_BIT 7
`define TLVI_EN_RST 8'h00
`define TLVI_PR_RST 8'h00
`define TLVI_PRI_PR_FIXED 8'h80
`define TLVI_VEC_BASE 16'h0003
`define TLVI_VEC_STEP 16'h0008
`define TLVI_CALL_CYC 3'h5
`define TLVI_AUTOCLR 17'h0_000F
`endif

// *** src/tlvi_handler.v ***
// vectored interrupt handler with two levels, wishbone register port and cpu call port
//
// The address map and register access over Wishbone were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "tlvi_defs.vh"

module tlvi_handler
(
  // clock, reset, enable
  input  wire        core_clk,
  input  wire        reset,
  input  wire        clk_en,
  // wishbone slave
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [5:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  // interrupt sources
  input  wire        external_irq_pin_0_n,
  input  wire        external_irq_pin_1_n,
  input  wire [16:0] src_event,
  input  wire [16:0] src_level,
  // cpu sequencer
  input  wire        instr_done,
  input  wire        return_from_interrupt_done,
  output reg         call_start,
  output reg         call_busy,
  output reg  [15:0] call_vector
);

  localparam ST_IDLE = 1'b0;
  localparam ST_CALL = 1'b1;

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  reg  [7:0]  pri_en_q;
  reg  [7:0]  pri_pr_q;
  reg  [7:0]  ext_en_a_q;
  reg  [7:0]  ext_pr_a_q;
  reg  [1:0]  ext_en_b_q;
  reg  [1:0]  ext_pr_b_q;
  reg  [16:0] pend_q;
  reg  [16:0] pend_d;
  reg         in_lo_q;
  reg         in_hi_q;
  reg         hold_one_q;
  reg         state_q;
  reg  [2:0]  cnt_q;
  reg         req_q;
  reg         req_hi_q;
  reg  [4:0]  req_idx_q;
  reg         run_hi_q;

  wire        bus_go;
  wire        wr;
  wire [16:0] enables;
  wire [16:0] levels;
  wire [16:0] active;
  wire        pin0_fall;
  wire        pin1_fall;
  wire [16:0] hw_set;
  wire        take;
  wire        level_ok;

  assign bus_go = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr     = bus_go & wb_we_i;

  // same bit positions in enable and priority registers
  assign enables = {ext_en_b_q, ext_en_a_q, pri_en_q[6:0]};
  assign levels  = {ext_pr_b_q, ext_pr_a_q, pri_pr_q[6:0]};
  // gate the ORed flags, leave them pending
  assign active  = (pend_q | src_level) & enables & {17{pri_en_q[`TLVI_GLOBAL_BIT]}};

  // ---------------------------------------------------------------
  // pin synchronisers, falling edge sets the external flags
  // ---------------------------------------------------------------
  // pins set the external flags through these
  tlvi_pin_sync u_pin0_sync
  (
    .core_clk (core_clk),
    .reset    (reset),
    .clk_en   (clk_en),
    .pin_n    (external_irq_pin_0_n),
    .fall     (pin0_fall)
  );

  tlvi_pin_sync u_pin1_sync
  (
    .core_clk (core_clk),
    .reset    (reset),
    .clk_en   (clk_en),
    .pin_n    (external_irq_pin_1_n),
    .fall     (pin1_fall)
  );
  // events set flags with no regard to enables
  assign hw_set = src_event | {14'h0000, pin1_fall, 1'b0, pin0_fall};

  // ---------------------------------------------------------------
  // arbitration, every cycle
  // ---------------------------------------------------------------
  reg        arb_req;
  reg        arb_hi;
  reg  [4:0] arb_idx;
  integer    i;

  always @*
  begin
    arb_req = 1'b0;
    arb_hi  = 1'b0;
    arb_idx = 5'd0;
    // high level first, lower index wins within a level
    for (i = `TLVI_NSRC - 1; i >= 0; i = i - 1)
    begin
      if (active[i] && levels[i] && !in_hi_q)
      begin
        arb_req = 1'b1;
        arb_hi  = 1'b1;
        arb_idx = i[4:0];
      end
    end
    if (!arb_req)
    begin
      for (i = `TLVI_NSRC - 1; i >= 0; i = i - 1)
      begin
        if (active[i] && !levels[i] && !in_hi_q && !in_lo_q)
        begin
          arb_req = 1'b1;
          arb_idx = i[4:0];
        end
      end
    end
  end

  // the decode is registered each cycle, the detect cycle
  always @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      req_q     <= 1'b0;
      req_hi_q  <= 1'b0;
      req_idx_q <= 5'd0;
    end
    else if (clk_en)
    begin
      req_q     <= arb_req;
      req_hi_q  <= arb_hi;
      req_idx_q <= arb_idx;
    end
  end

  // a level may have been entered since the request was registered
  assign level_ok = !in_hi_q && (req_hi_q || !in_lo_q);

  // a stale request is rechecked against the live flags, so a clear is honoured
  assign take = (state_q == ST_IDLE) && instr_done && req_q && !hold_one_q
                && active[req_idx_q] && level_ok;

  // ---------------------------------------------------------------
  // call sequencing and in-service levels
  // ---------------------------------------------------------------
  always @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      state_q     <= ST_IDLE;
      cnt_q       <= 3'd0;
      call_start  <= 1'b0;
      call_busy   <= 1'b0;
      call_vector <= 16'h0000;
      in_lo_q     <= 1'b0;
      in_hi_q     <= 1'b0;
      hold_one_q  <= 1'b0;
      run_hi_q    <= 1'b0;
    end
    else if (clk_en)
    begin
      call_start <= 1'b0;
      // after a return one instruction always runs
      if (return_from_interrupt_done)
        hold_one_q <= 1'b1;
      else if (instr_done)
        hold_one_q <= 1'b0;
      if (return_from_interrupt_done)
      begin
        if (in_hi_q)
          in_hi_q <= 1'b0;
        else
          in_lo_q <= 1'b0;
      end
      case (state_q)
        ST_IDLE:
        begin
          if (take)
          begin
            state_q     <= ST_CALL;
            cnt_q       <= `TLVI_CALL_CYC - 3'd1;
            call_start  <= 1'b1;
            call_busy   <= 1'b1;
            run_hi_q    <= req_hi_q;
            // vector grows by eight per order index
            call_vector <= `TLVI_VEC_BASE + {8'h00, req_idx_q, 3'b000};
          end
        end
        ST_CALL:
        begin
          // five cycles of long call before the routine runs
          if (cnt_q == 3'd0)
          begin
            state_q   <= ST_IDLE;
            call_busy <= 1'b0;
            if (run_hi_q)
              in_hi_q <= 1'b1;
            else
              in_lo_q <= 1'b1;
          end
          else
            cnt_q <= cnt_q - 3'd1;
        end
        default:
        begin
          state_q   <= ST_IDLE;
          call_busy <= 1'b0;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // pending flags: software write replaces, hardware set wins
  // ---------------------------------------------------------------
  always @*
  begin
    pend_d = pend_q;
    if (wr && wb_adr_i == `TLVI_ADR_PEND)
    begin
      if (wb_sel_i[0])
        pend_d[7:0] = wb_dat_i[7:0];
      if (wb_sel_i[1])
        pend_d[15:8] = wb_dat_i[15:8];
      if (wb_sel_i[2])
        pend_d[16] = wb_dat_i[16];
    end
    // only the first four flags clear on vectoring
    if (take)
      pend_d = pend_d & ~(`TLVI_AUTOCLR & (17'h0_0001 << req_idx_q));
    // a written 1 sets just like an event; events beat clears
    pend_d = pend_d | hw_set;
  end

  // ---------------------------------------------------------------
  // wishbone register file
  // ---------------------------------------------------------------
  always @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      pri_en_q   <= `TLVI_EN_RST;
      pri_pr_q   <= `TLVI_PR_RST;
      ext_en_a_q <= `TLVI_EN_RST;
      ext_pr_a_q <= `TLVI_PR_RST;
      ext_en_b_q <= 2'b00;
      ext_pr_b_q <= 2'b00;
      pend_q     <= 17'h0_0000;
      wb_ack_o   <= 1'b0;
      wb_dat_o   <= 32'h0000_0000;
    end
    else if (clk_en)
    begin
      pend_q   <= pend_d;
      wb_ack_o <= bus_go;
      if (wr && wb_sel_i[0])
      begin
        case (wb_adr_i)
          `TLVI_ADR_PRI_EN:   pri_en_q   <= wb_dat_i[7:0];
          `TLVI_ADR_PRI_PR:   pri_pr_q   <= wb_dat_i[7:0];
          `TLVI_ADR_EXT_EN_A: ext_en_a_q <= wb_dat_i[7:0];
          `TLVI_ADR_EXT_PR_A: ext_pr_a_q <= wb_dat_i[7:0];
          `TLVI_ADR_EXT_EN_B: ext_en_b_q <= wb_dat_i[1:0];
          `TLVI_ADR_EXT_PR_B: ext_pr_b_q <= wb_dat_i[1:0];
          default:            pri_en_q   <= pri_en_q;
        endcase
      end
      if (bus_go && !wb_we_i)
      begin
        case (wb_adr_i)
          `TLVI_ADR_PRI_EN:   wb_dat_o <= {24'h00_0000, pri_en_q};
          // top priority bit is fixed and reads as one
          `TLVI_ADR_PRI_PR:   wb_dat_o <= {24'h00_0000, pri_pr_q[6:0] | `TLVI_PRI_PR_FIXED};
          `TLVI_ADR_EXT_EN_A: wb_dat_o <= {24'h00_0000, ext_en_a_q};
          `TLVI_ADR_EXT_PR_A: wb_dat_o <= {24'h00_0000, ext_pr_a_q};
          `TLVI_ADR_EXT_EN_B: wb_dat_o <= {30'h0000_0000, ext_en_b_q};
          `TLVI_ADR_EXT_PR_B: wb_dat_o <= {30'h0000_0000, ext_pr_b_q};
          `TLVI_ADR_PEND:     wb_dat_o <= {15'h0000, pend_q};
          `TLVI_ADR_STAT:     wb_dat_o <= {21'h00_0000, state_q, hold_one_q,
                                           req_hi_q, req_q, in_hi_q, in_lo_q,
                                           req_idx_q};
          default:            wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule // tlvi_handler

// ---------------------------------------------------------------
// pin synchroniser: two flops, then a falling-edge detect
// ---------------------------------------------------------------
module tlvi_pin_sync
(
  // clock, reset, enable
  input  wire core_clk,
  input  wire reset,
  input  wire clk_en,
  // asynchronous pin, active low
  input  wire pin_n,
  // one-cycle pulse on a falling edge
  output wire fall
);

  reg  [1:0] sync_q;
  reg        old_q;

  // only the second flop is read; the first may be metastable
  always @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      // idle level of the pin, so no false edge follows reset
      sync_q <= 2'b11;
      old_q  <= 1'b1;
    end
    else if (clk_en)
    begin
      sync_q <= {sync_q[0], pin_n};
      old_q  <= sync_q[1];
    end
  end

  assign fall = old_q & ~sync_q[1];

endmodule // tlvi_pin_sync
`default_nettype wire

// *** verification/tlvi_cpu_model.sv ***
// behavioural cpu sequencer that retires instructions and returns from service
`timescale 1ns/100ps
`default_nettype none
module tlvi_cpu_model (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic reset,
  // handler and bench controls
  input  wire logic call_busy,
  input  wire logic slow,
  input  wire logic ret_req,
  // instruction boundaries
  output var  logic instr_done,
  output var  logic return_from_interrupt_done
);
  logic [3:0] cnt_q;
  logic       mode_q;
  logic       ret_q;
  // slow mode stretches every instruction except a return (always five cycles) to a divide's eight cycles
  always_ff @(posedge core_clk or posedge reset)
    if (reset)
    begin
      {cnt_q, mode_q, ret_q, instr_done, return_from_interrupt_done} <= '0;
    end
    else
    begin
      instr_done <= 1'b0;
      return_from_interrupt_done  <= 1'b0;
      if (ret_req) ret_q <= 1'b1;
      if (call_busy) cnt_q <= 4'h0;
      else if (cnt_q == (mode_q ? 4'h4 : (slow ? 4'h7 : 4'h0)))
      begin
        cnt_q      <= 4'h0;
        instr_done <= !mode_q;
        return_from_interrupt_done  <= mode_q;
        mode_q     <= ret_q || ret_req;
        ret_q      <= 1'b0;
      end
      else cnt_q <= cnt_q + 4'h1;
    end
endmodule // tlvi_cpu_model
`default_nettype wire

// *** verification/tlvi_handler_sva.sv ***
// concurrent checks on the handler's bus and call ports
`timescale 1ns/100ps
`default_nettype none
module tlvi_handler_sva (
  // clock, reset and enable
  input wire logic        core_clk,
  input wire logic        reset,
  input wire logic        clk_en,
  // register bus
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [5:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  // cpu port
  input wire logic        instr_done,
  input wire logic        return_from_interrupt_done,
  input wire logic        call_start,
  input wire logic        call_busy,
  input wire logic [15:0] call_vector
);
  default clocking cb @(posedge core_clk); endclocking
  // a frozen clock enable abandons every sequence in flight
  default disable iff (reset || !clk_en);
  ack_follows_req_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not answered");
  ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  unmapped_zero_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i > 6'h1C |-> !wb_dat_o)
    else $error("unmapped read not zero");
  call_on_boundary_a: assert property (call_start |-> $past(instr_done) && !$past(call_busy))
    else $error("call without instruction boundary");
  call_span_a: assert property (call_start |-> call_busy [*5] ##1 !call_busy)
    else $error("call length wrong");
  vector_form_a: assert property (call_start |-> call_vector[2:0] == 3'h3 && call_vector <= 16'h0083)
    else $error("vector outside table");
  vector_hold_a: assert property (!call_start |-> $stable(call_vector))
    else $error("vector moved between calls");
  return_from_interrupt_gap_a: assert property (return_from_interrupt_done ##1 instr_done |=> !call_start)
    else $error("call right after return");
endmodule // tlvi_handler_sva
`default_nettype wire

// *** verification/tb_top.sv ***
// self-checking bench for the two-level interrupt handler
`timescale 1ns/100ps
`default_nettype none
`include "tlvi_defs.vh"
module tb_top;
  logic        core_clk = 0, reset = 1, cyc = 0, we = 0, ret_req = 0, slow = 0, p0_n = 1;
  logic        p1_n = 1;
  logic [5:0]  adr = 6'h00;
  logic [31:0] wdat = 32'h0000_0000, rdat, rd_q, lfsr = 32'h478a_36b6;
  logic [16:0] ev = 17'h0_0000, lvl = 17'h0_0000, p, pr;
  logic        ack, instr_done, return_from_interrupt_done, call_start, call_busy;
  logic [15:0] vec;
  int          err_count = 0, n_checks = 0, calls = 0, c;
  tlvi_handler DUT (.core_clk, .reset, .clk_en(1'b1), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .external_irq_pin_0_n(p0_n), .external_irq_pin_1_n(p1_n), .src_event(ev),
    .src_level(lvl), .instr_done, .return_from_interrupt_done, .call_start, .call_busy,
    .call_vector(vec));
  tlvi_cpu_model cpu (.core_clk, .reset, .call_busy, .slow, .ret_req, .instr_done, .return_from_interrupt_done);
  initial forever #25 core_clk = ~core_clk;
  always @(posedge core_clk) if (call_start === 1'b1) calls++;
  // ----
  // helpers
  // ----
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [15:0] winner(input logic [16:0] f, lv);
    for (int i = 0; i < 17; i++) if (f[i] && lv[i]) return 16'h0003 + 16'(8 * i);
    for (int i = 0; i < 17; i++) if (f[i]) return 16'h0003 + 16'(8 * i);
    return 16'h0000;
  endfunction
  task automatic check(input logic [31:0] got, exp);
    n_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [5:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge core_clk);
    cyc <= 1; we <= w; adr <= a; wdat <= d;
    @(posedge core_clk);
    while (ack !== 1'b1 && n++ < 20) @(posedge core_clk);
    if (ack !== 1'b1) err_count++;
    rd_q = rdat;
    cyc <= 0;
  endtask
  task automatic rd(input logic [5:0] a, input logic [31:0] exp);
    wb(0, a, 32'h0000_0000);
    check(rd_q, exp);
  endtask
  task automatic wait_call(input logic [15:0] exp);
    int n = 0;
    while (call_start !== 1'b1 && n++ < 200) @(posedge core_clk);
    check({15'h0000, call_start, vec}, {16'h0001, exp});
    do @(posedge core_clk); while (call_busy === 1'b1);
  endtask
  task automatic ret;
    ret_req <= 1;
    @(posedge core_clk);
    ret_req <= 0;
    @(posedge return_from_interrupt_done);
  endtask
  task automatic quiet;
    c = calls;
    repeat (30) @(posedge core_clk);
    check(calls, c);
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    #200000;
    err_count++;
    summarize();
  end
  initial
  begin
    repeat (8) @(posedge core_clk);
    reset <= 0;
    wb(1, 6'h24, 32'hFFFF_FFFF);
    for (int a = 0; a < 10; a++) if (a != 7) rd(6'(4 * a), a == 1 ? 32'h80 : 32'h0);
    $display("test reset values done");
    wb(1, `TLVI_ADR_PRI_PR, 32'h03);
    wb(1, `TLVI_ADR_PRI_EN, 32'hA3);
    ev <= 17'h0_0040; @(posedge core_clk); ev <= 17'h0_0000;
    quiet();
    ev <= 17'h0_0020; @(posedge core_clk); ev <= 17'h0_0000;
    wait_call(16'h002B);
    ev <= 17'h0_0002; @(posedge core_clk); ev <= 17'h0_0000;
    wait_call(16'h000B);
    p0_n <= 0;
    quiet();
    rd(`TLVI_ADR_PEND, 32'h0_0061);
    ret();
    wait_call(16'h0003);
    p0_n <= 1;
    wb(1, `TLVI_ADR_PEND, 32'h0);
    ret();
    ret();
    $display("test preemption done");
    wb(1, `TLVI_ADR_EXT_EN_A, 32'hFF);
    wb(1, `TLVI_ADR_EXT_EN_B, 32'h03);
    for (int k = 0; k < 8; k++)
    begin
      lfsr = nxt(lfsr); pr = lfsr[16:0]; slow <= lfsr[31];
      lfsr = nxt(lfsr); p = lfsr[16:0] | 17'h1_0000;
      wb(1, `TLVI_ADR_PRI_EN, 32'h7F);
      wb(1, `TLVI_ADR_PRI_PR, {25'h0, pr[6:0]});
      wb(1, `TLVI_ADR_EXT_PR_A, {24'h0, pr[14:7]});
      wb(1, `TLVI_ADR_EXT_PR_B, {30'h0, pr[16:15]});
      wb(1, `TLVI_ADR_PEND, {15'h0, p});
      quiet();
      rd(`TLVI_ADR_PEND, {15'h0, p});
      wb(1, `TLVI_ADR_PRI_EN, 32'hFF);
      wait_call(winner(p, pr));
      wb(1, `TLVI_ADR_PEND, 32'h0);
      ret();
    end
    $display("test arbitration done");
    wb(1, `TLVI_ADR_PRI_PR, 32'h0);
    wb(1, `TLVI_ADR_EXT_PR_A, 32'h0);
    wb(1, `TLVI_ADR_EXT_PR_B, 32'h0);
    lvl <= 17'h0_0200;
    wait_call(16'h004B);
    lvl <= 17'h0_0000;
    ret();
    p1_n <= 0;
    wait_call(16'h0013);
    p1_n <= 1;
    rd(`TLVI_ADR_PEND, 32'h0);
    ret();
    $display("test level and pin sources done");
    summarize();
  end
endmodule // tb_top
bind tlvi_handler tlvi_handler_sva u_sva (.core_clk, .reset, .clk_en, .wb_cyc_i, .wb_stb_i,
  .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .instr_done, .return_from_interrupt_done, .call_start,
  .call_busy, .call_vector);
`default_nettype wire
